// ### logic/bpm_defines.vh
// Purpose: Shared constants for the battery power-mode controller
// Assumes: Plain Verilog-2005, included by bare name
// Notes:   Voltages in millivolts
`ifndef BPM_DEFINES_VH
`define BPM_DEFINES_VH

`define BPM_CAL_SHIFT        14
`define BPM_WAKE_IO_BIT      6
`define BPM_WAKE_BUS_BIT     5
`define BPM_WAKE_CUR_BIT     4
`define BPM_WAKE_VOLT_BIT    3
`define BPM_WAKE_SEL_HI      2
`define BPM_WAKE_SEL_LO      0
`define BPM_WAKE_SOURCES     4
`define BPM_WAKE_CFG_RESET   8'h00
`define BPM_MIN_INTERVAL     16'h0002
`define BPM_CONSEC_NEEDED    2'h2
`define BPM_WAKE_MV_0        16'h1900
`define BPM_WAKE_MV_1        16'h1A04
`define BPM_WAKE_MV_2        16'h22B0
`define BPM_WAKE_MV_3        16'h2580
`define BPM_WAKE_MV_4        16'h2706
`define BPM_WAKE_MV_5        16'h2B5C
`define BPM_WAKE_MV_6        16'h3200
`define BPM_WAKE_MV_7        16'h33F4

`endif

// ### logic/bpm_threshold.v
// Purpose: Run/sample current threshold from limit and gain calibration
// Assumes: Unsigned operands, registered result
// Notes:   Same magnitude applies to charge and discharge
`default_nettype none
`include "bpm_defines.vh"

module bpm_threshold #(
	parameter W = 16
) (
	input  wire         clock,
	input  wire         rst_n,
	input  wire [W-1:0] run_threshold_param,
	input  wire [W-1:0] current_gain_cal,
	output reg  [W-1:0] threshold
);
	wire [2*W-1:0] product;
	wire [2*W-1:0] scaled;

	assign product = run_threshold_param * current_gain_cal;
	assign scaled  = product >> `BPM_CAL_SHIFT;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			threshold <= {W{1'b0}};
		end else begin
			threshold <= scaled[W-1:0];
		end
	end
endmodule
`default_nettype wire

// ### logic/bpm_wake_decode.v
// Purpose: Decode wake configuration byte into enables and wake level
// Assumes: Level table in millivolts
// Notes:   Purely combinational
`default_nettype none
`include "bpm_defines.vh"

module bpm_wake_decode (
	input  wire [7:0]  wake_config,
	output wire        wake_on_io_en,
	output wire        wake_on_bus_en,
	output wire        wake_on_current_en,
	output wire        wake_on_voltage_en,
	output reg  [15:0] wake_level_mv
);
	wire [2:0] wake_voltage_select;

	assign wake_on_io_en       = wake_config[`BPM_WAKE_IO_BIT];
	assign wake_on_bus_en      = wake_config[`BPM_WAKE_BUS_BIT];
	assign wake_on_current_en  = wake_config[`BPM_WAKE_CUR_BIT];
	assign wake_on_voltage_en  = wake_config[`BPM_WAKE_VOLT_BIT];
	assign wake_voltage_select = wake_config[`BPM_WAKE_SEL_HI:`BPM_WAKE_SEL_LO];

	always @* begin
		case (wake_voltage_select)
			3'h0: wake_level_mv = `BPM_WAKE_MV_0;
			3'h1: wake_level_mv = `BPM_WAKE_MV_1;
			3'h2: wake_level_mv = `BPM_WAKE_MV_2;
			3'h3: wake_level_mv = `BPM_WAKE_MV_3;
			3'h4: wake_level_mv = `BPM_WAKE_MV_4;
			3'h5: wake_level_mv = `BPM_WAKE_MV_5;
			3'h6: wake_level_mv = `BPM_WAKE_MV_6;
			default: wake_level_mv = `BPM_WAKE_MV_7;
		endcase
	end
endmodule
`default_nettype wire

// ### logic/bpm_mode_ctrl.v
// Purpose: Run / Sample / Sleep power-mode controller of a battery manager
// Assumes: period_tick is one clock wide, once per measurement period;
//          meas_done pulses once when a conversion set has finished
// Notes:   Outputs other than wake_config register the next state, so they move with power_mode
// Operation
// - Threshold equals limit times gain over 16384
// - Enter Run after two readings above threshold
// - Run exits only to Sample
// - Leave Run after two readings below threshold
// - Run measures and calculates every period
// - Sample goes to Run or Sleep
// - Sample measures once per interval count, min two
// - Converter idle in other Sample periods
// - Sleep when pack voltage below limit in Sample
// - No Sleep while current holds Run
// - Sleep exits to Run on enabled wake
// - Sleep: no measure, calc, display, bus
// - Four individually enabled wake sources
// - Wake byte bit layout
// - Wake level table selects voltage threshold
`default_nettype none
`include "bpm_defines.vh"

module bpm_mode_ctrl #(
	parameter CW = 16,
	parameter VW = 16
) (
	input  wire          clock,
	input  wire          reset_n,
	input  wire          period_tick,
	input  wire          meas_done,
	input  wire [CW-1:0] current_magnitude,
	input  wire [VW-1:0] pack_voltage_input,
	input  wire [CW-1:0] run_threshold_param,
	input  wire [CW-1:0] current_gain_cal,
	input  wire [15:0]   sample_interval_count,
	input  wire [VW-1:0] sleep_voltage_limit,
	input  wire          wake_cfg_write,
	input  wire [7:0]    wake_cfg_wdata,
	input  wire          bus_activity,
	input  wire          io_activity,
	output reg  [7:0]    wake_config,
	output reg  [2:0]    power_mode,
	output reg           meas_start,
	output reg           calc_enable,
	output reg           bus_enable,
	output reg           display_enable,
	output reg           converter_enable
);
	localparam ST_SAMPLE = 3'b001;
	localparam ST_RUN    = 3'b010;
	localparam ST_SLEEP  = 3'b100;

	reg           rst_meta;
	reg           rst_n;
	reg  [2:0]    state;
	reg  [2:0]    next_state;
	reg  [1:0]    above_count;
	reg  [1:0]    below_count;
	reg  [15:0]   interval_count;
	reg           meas_period;
	wire [CW-1:0] threshold;
	wire          wake_on_io_en;
	wire          wake_on_bus_en;
	wire          wake_on_current_en;
	wire          wake_on_voltage_en;
	wire [15:0]   wake_level_mv;
	wire [15:0]   interval_limit;
	wire          interval_hit;
	wire          is_above;
	wire          is_below;
	wire          wake_hit;
	// Wake source vectors, io at the top down to voltage at bit 0
	wire          volt_at_level;
	wire [3:0]    wake_src_en;
	wire [3:0]    wake_src_req;
	wire [3:0]    wake_src_hit;
	wire          mode_change;
	wire          run_next;
	wire          sleep_next;
	wire          sample_stay;
	wire          start_now;
	wire          conv_now;

	// Saturating so a long run of readings never wraps back to zero
	// Shared by the above and the below count
	function [1:0] consec_next;
		input [1:0] count;
		input       hit;
		begin
			if (!hit) begin
				consec_next = 2'h0;
			end else if (&count) begin
				consec_next = count;
			end else begin
				consec_next = count + 2'h1;
			end
		end
	endfunction

	// Reset release through two flops
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	bpm_threshold #(
		.W (CW)
	) u_thr (
		.clock               (clock),
		.rst_n               (rst_n),
		.run_threshold_param (run_threshold_param),
		.current_gain_cal    (current_gain_cal),
		.threshold           (threshold)
	);

	bpm_wake_decode u_wake (
		.wake_config        (wake_config),
		.wake_on_io_en      (wake_on_io_en),
		.wake_on_bus_en     (wake_on_bus_en),
		.wake_on_current_en (wake_on_current_en),
		.wake_on_voltage_en (wake_on_voltage_en),
		.wake_level_mv      (wake_level_mv)
	);

	// Counts below two are clamped so the converter never runs every period in Sample
	assign interval_limit = (sample_interval_count < `BPM_MIN_INTERVAL) ?
		`BPM_MIN_INTERVAL : sample_interval_count;
	assign interval_hit = (interval_count >= interval_limit - 16'h0001);

	// Mode-change helpers; every output below except wake_config is built from the next state
	assign mode_change = (next_state != state);
	assign run_next    = (next_state == ST_RUN);
	assign sleep_next  = (next_state == ST_SLEEP);
	assign sample_stay = (state == ST_SAMPLE) && (next_state == ST_SAMPLE);
	// A conversion set starts every tick in Run, on the counted tick in Sample
	assign start_now = period_tick && (run_next || (sample_stay && interval_hit));
	// Converter stays powered from the counted tick up to the next tick
	assign conv_now  = run_next || (sample_stay && (period_tick ? interval_hit : meas_period));

	assign is_above = (current_magnitude > threshold);
	assign is_below = (current_magnitude < threshold);

	// Wake compares use live inputs since the converter is off in sleep
	assign volt_at_level = (pack_voltage_input >= wake_level_mv);
	assign wake_src_en   = {wake_on_io_en, wake_on_bus_en, wake_on_current_en, wake_on_voltage_en};
	assign wake_src_req  = {io_activity, bus_activity, is_above, volt_at_level};

	// One gate per source, bit order as in the wake byte
	genvar g;
	generate
		for (g = 0; g < `BPM_WAKE_SOURCES; g = g + 1) begin : g_wake
			assign wake_src_hit[g] = wake_src_en[g] && wake_src_req[g];
		end
	endgenerate
	assign wake_hit = |wake_src_hit;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wake_config <= `BPM_WAKE_CFG_RESET;
		end else if (wake_cfg_write && (state != ST_SLEEP)) begin
			wake_config <= wake_cfg_wdata;
		end
	end

	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (meas_done && is_below && (below_count == `BPM_CONSEC_NEEDED - 2'h1)) begin
					next_state = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				if (meas_done && is_above && (above_count == `BPM_CONSEC_NEEDED - 2'h1)) begin
					next_state = ST_RUN;
					// Sleep is judged on this reading's voltage, never a stale one
				end else if (meas_done && !is_above && (pack_voltage_input < sleep_voltage_limit)) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake_hit) begin
					next_state = ST_RUN;
				end
			end
			default: next_state = ST_SAMPLE;
		endcase
	end

	// Power mode register; only next_state moves it
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_SAMPLE;
		end else begin
			state <= next_state;
		end
	end

	// Consecutive readings restart on every mode change, wake-up included
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			above_count <= 2'h0;
		end else if (mode_change) begin
			above_count <= 2'h0;
		end else if (meas_done) begin
			above_count <= consec_next(above_count, is_above);
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			below_count <= 2'h0;
		end else if (mode_change) begin
			below_count <= 2'h0;
		end else if (meas_done) begin
			below_count <= consec_next(below_count, is_below);
		end
	end

	// Interval only advances in Sample; Run measures every period anyway
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			interval_count <= 16'h0000;
		end else if (mode_change) begin
			interval_count <= 16'h0000;
		end else if (period_tick && (state == ST_SAMPLE)) begin
			interval_count <= interval_hit ? 16'h0000 : interval_count + 16'h0001;
		end
	end

	// Marks the Sample period whose tick started a conversion set
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meas_period <= 1'b0;
		end else if (mode_change) begin
			meas_period <= 1'b0;
		end else if (period_tick) begin
			meas_period <= (state == ST_SAMPLE) && interval_hit;
		end
	end

	// Outputs come from the next state so they move together with power_mode
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			power_mode <= ST_SAMPLE;
		end else begin
			power_mode <= next_state;
		end
	end

	// One start pulse on each tick that the mode selects
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meas_start <= 1'b0;
		end else begin
			meas_start <= start_now;
		end
	end

	// Calculations keep the Run rate in Sample and stop in Sleep
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			calc_enable <= 1'b0;
		end else begin
			calc_enable <= period_tick && !sleep_next;
		end
	end

	// Bus service ends on the same edge that enters Sleep
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_enable <= 1'b0;
		end else begin
			bus_enable <= !sleep_next;
		end
	end

	// Display is off for the whole of Sleep
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			display_enable <= 1'b0;
		end else begin
			display_enable <= !sleep_next;
		end
	end

	// Converter power follows the measuring period only
	// Entering Run powers it at once, entering Sleep drops it at once
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			converter_enable <= 1'b0;
		end else begin
			converter_enable <= conv_now;
		end
	end
endmodule
`default_nettype wire

// ### tb/bpm_checker.sv
// Purpose: Port assertions for the power-mode controller
// Assumes: Threshold inputs steady
// Notes:   Flags hold the previous reading
`default_nettype none
module bpm_checker #(
	parameter CW = 16
) (
	input wire logic          clock,
	input wire logic          reset_n,
	input wire logic          meas_done,
	input wire logic [CW-1:0] current_magnitude,
	input wire logic [CW-1:0] run_threshold_param,
	input wire logic [CW-1:0] current_gain_cal,
	input wire logic [2:0]    power_mode,
	input wire logic          meas_start,
	input wire logic          calc_enable,
	input wire logic          converter_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2*CW-1:0] prod;
	logic            smp, run, slp, above, below, hi_q, lo_q;
	assign {slp, run, smp} = power_mode;
	assign prod = run_threshold_param * current_gain_cal;
	assign above = current_magnitude > prod[CW+13:14];
	assign below = current_magnitude < prod[CW+13:14];
	// Cleared in sleep so a wake starts a fresh count
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n) {hi_q, lo_q} <= 2'h0;
		else if (meas_done) {hi_q, lo_q} <= {above, below};
		else if (slp) {hi_q, lo_q} <= 2'h0;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_hi2; smp && meas_done && above && hi_q; endsequence
	sequence s_lo2; run && meas_done && below && lo_q; endsequence
	property p_run_in; s_hi2 |=> run; endproperty
	a_run_in: assert property (p_run_in) else $error("no run entry");
	property p_run_gate; smp && !(meas_done && above && hi_q) |=> !run; endproperty
	a_run_gate: assert property (p_run_gate) else $error("early run");
	property p_run_out; s_lo2 |=> smp; endproperty
	a_run_out: assert property (p_run_out) else $error("no run exit");
	property p_run_stay; run |=> !slp; endproperty
	a_run_stay: assert property (p_run_stay) else $error("run to sleep");
	property p_slp_src; $rose(slp) |-> $past(smp); endproperty
	a_slp_src: assert property (p_slp_src) else $error("sleep source");
	property p_wake; slp |=> slp || run; endproperty
	a_wake: assert property (p_wake) else $error("bad sleep exit");
	property p_quiet; slp |-> !(calc_enable || meas_start || converter_enable); endproperty
	a_quiet: assert property (p_quiet) else $error("active in sleep");
	property p_conv; run |-> converter_enable; endproperty
	a_conv: assert property (p_conv) else $error("converter off in run");
endmodule
bind bpm_mode_ctrl bpm_checker #(.CW(CW)) i_chk (.*);
`default_nettype wire

// ### tb/bpm_conv_model.sv
// Purpose: Converter model, one reading per start
// Assumes: Bench sets the reading values
// Notes:   While powered and not done, the data lines show inverted values
`default_nettype none
module bpm_conv_model #(
	parameter DLY = 3
) (
	input  wire logic        clock,
	input  wire logic        meas_start,
	input  wire logic        converter_enable,
	input  wire logic [15:0] cur,
	input  wire logic [15:0] vol,
	output var  logic        meas_done,
	output wire logic [15:0] current_magnitude,
	output wire logic [15:0] pack_voltage_input
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial meas_done = 1'h0;
	// Conversions run back to back, so a set takes DLY clocks
	always @(posedge clock) begin
		meas_done <= (cnt == 1);
		cnt <= (meas_start === 1'h1) ? DLY : (cnt > 0 ? cnt - 1 : 0);
	end
	// Unpowered, the lines track the pack directly for the wake compares
	assign current_magnitude  = (meas_done || !converter_enable) ? cur : ~cur;
	assign pack_voltage_input = (meas_done || !converter_enable) ? vol : ~vol;
endmodule
`default_nettype wire

// ### tb/test_battery_power_mode_controller.sv
// Purpose: Directed bench for the power-mode controller
// Assumes: Tick every 10 clocks, interval 4, threshold 20
// Notes:   Sleep limit 5000 mV
`default_nettype none
module test_battery_power_mode_controller;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'h0, reset_n = 1'h0, period_tick = 1'h0, go = 1'h0, wake_cfg_write = 1'h0;
	logic        bus_activity = 1'h0, io_activity = 1'h0, meas_done, meas_start, calc_enable;
	logic        bus_enable, display_enable, converter_enable;
	logic [15:0] cur = 16'h0015, vol = 16'h1F40, current_magnitude, pack_voltage_input;
	logic [7:0]  wake_cfg_wdata = 8'h00, wake_config;
	logic [2:0]  power_mode;
	int          err_total = 0, checked = 0, starts = 0, k;
	logic [15:0] lv [8] = '{16'h1900, 16'h1A04, 16'h22B0, 16'h2580, 16'h2706, 16'h2B5C, 16'h3200, 16'h33F4};
	bpm_mode_ctrl i_dut (.*, .run_threshold_param(16'h001B), .current_gain_cal(16'h30D4),
		.sample_interval_count(16'h0004), .sleep_voltage_limit(16'h1388));
	bpm_conv_model i_conv (.*);
	initial forever #20 clock = ~clock;
	always begin
		repeat (9) @(posedge clock);
		#1 period_tick = go;
		@(posedge clock);
		#1 period_tick = 1'h0;
	end
	always @(posedge clock) if (meas_start === 1'h1) starts <= starts + 1;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wait_mode(input logic [2:0] m);
		for (int i = 0; i < 600 && power_mode !== m; i++) @(posedge clock);
		#1 check({13'h0000, power_mode}, {13'h0000, m});
		if (power_mode !== m) test_done;
	endtask
	task automatic count_starts(input int cyc, input logic [15:0] exp);
		int s0;
		#1 s0 = starts;
		repeat (cyc) @(posedge clock);
		#1 check(16'(starts - s0), exp);
	endtask
	task automatic wr_cfg(input logic [7:0] d);
		@(posedge clock);
		#1 {wake_cfg_write, wake_cfg_wdata} = {1'h1, d};
		@(posedge clock);
		#1 wake_cfg_write = 1'h0;
	endtask
	initial begin
		repeat (3) @(posedge clock);
		check({5'h00, power_mode, wake_config}, 16'h0100);
		#1 reset_n = 1'h1;
		repeat (3) @(posedge clock);
		#1 go = 1'h1;
		wait_mode(3'h2);
		cur = 16'h0014;
		count_starts(40, 16'h0004);
		check({13'h0000, power_mode}, 16'h0002);
		cur = 16'h0005;
		wait_mode(3'h1);
		count_starts(80, 16'h0002);
		check({14'h0000, bus_enable, display_enable}, 16'h0003);
		wr_cfg(8'h40);
		check({8'h00, wake_config}, 16'h0040);
		vol = 16'h0BB8;
		wait_mode(3'h4);
		check({12'h000, calc_enable, bus_enable, display_enable, converter_enable}, 16'h0000);
		wr_cfg(8'h20);
		bus_activity = 1'h1;
		repeat (20) @(posedge clock);
		check({5'h00, power_mode, wake_config}, 16'h0440);
		#1 io_activity = 1'h1;
		wait_mode(3'h2);
		{bus_activity, io_activity} = 2'h0;
		for (k = 0; k < 8; k++) begin
			wr_cfg({5'h01, k[2:0]});
			vol = 16'h0BB8;
			wait_mode(3'h4);
			vol = lv[k] - 16'h0001;
			repeat (4) @(posedge clock);
			#1 check({13'h0000, power_mode}, 16'h0004);
			vol = lv[k];
			wait_mode(3'h2);
		end
		test_done;
	end
endmodule
`default_nettype wire
